// ===== inc/keyscan_pkg.sv
`default_nettype none
package keyscan_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_ROWS = 18;
    localparam int NUM_COLS = 8;
    localparam int ADDR_W   = 5;
    localparam int SEL_W    = 5;
    localparam int CNT_W    = 2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ROW_SEL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_COL_IN   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_COL_STAT = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_COL_IEN  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_EXT_CTL  = 5'h14;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int BIT_SEL_LSB   = 0;
    localparam int BIT_DRIVE_ALL = 5;
    localparam int BIT_DISABLE   = 6;
    localparam int BIT_INVERT    = 7;
    localparam int BIT_PREDRIVE  = 0;
    localparam logic [SEL_W-1:0] ROW_SEL_LAST = 5'h11;
    localparam logic [2:0]       SIZE_WORD    = 3'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ      = 40_000_000;
    localparam int PREDRIVE_REF_HZ  = 48_000_000;
    localparam int PREDRIVE_REF_CYC = 2;
    localparam int PREDRIVE_CYC_INT =
        (PREDRIVE_REF_CYC * CLK_FREQ_HZ + PREDRIVE_REF_HZ - 1) / PREDRIVE_REF_HZ;
    localparam logic [CNT_W-1:0] PREDRIVE_CNT = CNT_W'(PREDRIVE_CYC_INT);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_LOW    = 2'b01,
        PS_ACTIVE = 2'b10
    } pwr_state_t;

    typedef struct packed {
        logic             row_polarity_invert;
        logic             scan_disable;
        logic             row_drive_all;
        logic [SEL_W-1:0] row_select;
    } row_ctl_t;

    localparam row_ctl_t ROW_CTL_RST = 8'h40;

    typedef struct packed {
        pwr_state_t                       pwr;
        row_ctl_t                         ctl;
        logic [NUM_COLS-1:0]              column_irq_enables;
        logic [NUM_COLS-1:0]              column_edge_flags;
        logic                             predrive_en;
        logic [NUM_COLS-1:0]              col_prev;
        logic [NUM_COLS-1:0]              col_snap;
        logic                             fired;
        logic                             irq;
        logic                             wake;
        logic                             wr_pend;
        logic [ADDR_W-1:0]                wr_addr;
        logic [31:0]                      rdata;
        logic [NUM_ROWS-1:0]              row_lvl;
        logic [NUM_ROWS-1:0]              row_oe;
        logic [NUM_ROWS-1:0][CNT_W-1:0]   cnt;
    } state_t;

    localparam state_t ST_RST = '{
        pwr      : PS_LOW,
        ctl      : ROW_CTL_RST,
        col_prev : 8'hff,
        default  : '0
    };

endpackage
`default_nettype wire

// ===== hdl/keyboard_matrix_scan.sv
// Functional notes
// R1 - block falls to low power by itself when no scan is running
// R2 - scan disable forces the low-power state
// R3 - sleep is inhibited only while active, never in low power
// R4 - predrive drives rows high briefly before releasing to open drain
// R5 - predrive enable is extended control bit 0, high drive two 48 MHz cycles
// R6 - software enables predrive with scan disabled, pads push-pull first
// R7 - software disables predrive with scan disabled, pads open-drain first
// R8 - pads push-pull with predrive, else open-drain with pull-ups
// R9 - column falling edges are caught without the bus clock
// R10 - runtime interrupt is an active-high level
// R11 - each column flag sets on its high-to-low transition
// R12 - a column term is low when its flag or enable is clear
// R13 - writing one clears a column flag, zero leaves it
// R14 - runtime interrupt is the OR of all eight column terms
// R15 - after firing, no new interrupt until columns all high or changed
// R16 - enabled column edge with bus clock stopped raises wake request
// R17 - wake also requests a clock and holds until bus clock runs
// R18 - sleep edges set flags; runtime interrupt follows once clock resumes
// R19 - scan disable is bit 6, resets to one, tristates all rows
// R20 - valid select drives chosen row low, others high; invert swaps
// R21 - out-of-range select drives all rows high, or low if inverted
// R22 - drive-all drives every row high, or low if inverted
// R23 - column input register reads live column pins
// R24 - all logic runs on the single block clock
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module keyboard_matrix_scan
    import keyscan_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    input  wire logic                CLK_EN,
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    input  wire logic [NUM_COLS-1:0] COLUMN_INPUT,
    input  wire logic                BUS_CLK_RUNNING,
    output logic      [NUM_ROWS-1:0] ROW_OUTPUT,
    output logic      [NUM_ROWS-1:0] ROW_OUTPUT_OE,
    output logic                     SCAN_RUNTIME_IRQ,
    output logic                     SCAN_WAKE_REQUEST,
    output logic                     SCAN_WAKE_SIGNAL,
    output logic                     SLEEP_INHIBIT,
    output logic                     LOW_POWER
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_t                          st_r;
    state_t                          st_nxt;

    logic                            acc;
    logic                            rd_acc;
    logic [ADDR_W-1:0]               acc_addr;
    logic [NUM_COLS-1:0]             fall;
    logic [NUM_COLS-1:0]             term;
    logic                            any_term;
    logic                            rearm;
    logic                            wake_ev;
    logic                            sel_valid;
    logic                            scan_en;
    logic                            busy;
    logic [NUM_ROWS-1:0]             lvl_w;
    logic [NUM_ROWS-1:0]             oe_w;
    logic [NUM_ROWS-1:0][CNT_W-1:0]  cnt_w;

    // ----------------------------------------------------------------
    // bus address phase
    // ----------------------------------------------------------------
    assign acc      = HSEL & HTRANS[1] & HREADY & (HSIZE == SIZE_WORD);
    assign rd_acc   = acc & ~HWRITE;
    assign acc_addr = HADDR[ADDR_W-1:0];

    // ----------------------------------------------------------------
    // column edges and interrupt terms
    // ----------------------------------------------------------------
    assign fall     = st_r.col_prev & ~COLUMN_INPUT; // R9 R11
    assign term     = st_r.column_edge_flags & st_r.column_irq_enables; // R12
    assign any_term = (|term) & BUS_CLK_RUNNING; // R14 R18
    assign rearm    = (&COLUMN_INPUT) | (COLUMN_INPUT != st_r.col_snap); // R15
    assign wake_ev  = (|(fall & st_r.column_irq_enables)) & ~BUS_CLK_RUNNING; // R16

    // ----------------------------------------------------------------
    // row drive decode
    // ----------------------------------------------------------------
    assign scan_en   = ~st_r.ctl.scan_disable; // R19
    assign sel_valid = (st_r.ctl.row_select <= ROW_SEL_LAST) & ~st_r.ctl.row_drive_all;

    generate
        for (genvar i = 0; i < NUM_ROWS; i++)
        begin : g_row
            logic hit;
            logic lvl;
            logic load;

            // R20 R21 R22
            assign hit  = sel_valid & (st_r.ctl.row_select == SEL_W'(i));
            assign lvl  = hit ? st_r.ctl.row_polarity_invert : ~st_r.ctl.row_polarity_invert;
            assign lvl_w[i] = scan_en & lvl;
            // R4 R5
            assign load = st_r.predrive_en & lvl_w[i] & ~st_r.row_lvl[i];
            assign cnt_w[i] = load ? PREDRIVE_CNT :
                              ((scan_en && st_r.cnt[i] != '0) ? st_r.cnt[i] - 1'b1 : '0);
            assign oe_w[i]  = scan_en & (~lvl | (cnt_w[i] != '0)); // R19 R4
        end
    endgenerate

    // ----------------------------------------------------------------
    // activity
    // ----------------------------------------------------------------
    assign busy = scan_en & (sel_valid | (|st_r.row_oe) | st_r.wr_pend); // R1 R2

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.wr_pend  = acc & HWRITE;
        st_nxt.col_prev = COLUMN_INPUT;

        if (acc)
        begin
            st_nxt.wr_addr = acc_addr;
        end

        // register writes in the data phase
        st_nxt.column_edge_flags = st_r.column_edge_flags | fall; // R11
        if (st_r.wr_pend)
        begin
            unique case (st_r.wr_addr)
                OFS_ROW_SEL:
                begin
                    st_nxt.ctl = row_ctl_t'(HWDATA[7:0]);
                end
                OFS_COL_STAT:
                begin
                    st_nxt.column_edge_flags =
                        (st_r.column_edge_flags & ~HWDATA[NUM_COLS-1:0]) | fall; // R13
                end
                OFS_COL_IEN:
                begin
                    st_nxt.column_irq_enables = HWDATA[NUM_COLS-1:0];
                end
                OFS_EXT_CTL:
                begin
                    st_nxt.predrive_en = HWDATA[BIT_PREDRIVE]; // R5
                end
                default:
                begin
                    st_nxt.wr_pend = st_nxt.wr_pend;
                end
            endcase
        end

        // read data, taken after any write of the same cycle
        if (rd_acc)
        begin
            unique case (acc_addr)
                OFS_ROW_SEL:
                begin
                    st_nxt.rdata = {24'h000000, st_nxt.ctl};
                end
                OFS_COL_IN:
                begin
                    st_nxt.rdata = {24'h000000, COLUMN_INPUT}; // R23
                end
                OFS_COL_STAT:
                begin
                    st_nxt.rdata = {24'h000000, st_nxt.column_edge_flags};
                end
                OFS_COL_IEN:
                begin
                    st_nxt.rdata = {24'h000000, st_nxt.column_irq_enables};
                end
                OFS_EXT_CTL:
                begin
                    st_nxt.rdata = {31'h00000000, st_nxt.predrive_en};
                end
                default:
                begin
                    st_nxt.rdata = 32'h00000000;
                end
            endcase
        end

        // runtime interrupt with one-shot rearm
        st_nxt.irq = any_term & (st_r.irq | ~st_r.fired); // R10 R14 R15
        if (st_nxt.irq & ~st_r.irq)
        begin
            st_nxt.fired    = 1'b1;
            st_nxt.col_snap = COLUMN_INPUT;
        end
        else if (~st_nxt.irq & rearm)
        begin
            st_nxt.fired = 1'b0; // R15
        end

        // wake request and clock request
        if (BUS_CLK_RUNNING)
        begin
            st_nxt.wake = 1'b0; // R17
        end
        else if (wake_ev)
        begin
            st_nxt.wake = 1'b1; // R16 R17
        end

        // rows
        st_nxt.row_lvl = lvl_w;
        st_nxt.row_oe  = oe_w;
        st_nxt.cnt     = cnt_w;

        // power state
        unique case (st_r.pwr)
            PS_LOW:
            begin
                if (busy)
                begin
                    st_nxt.pwr = PS_ACTIVE;
                end
            end
            PS_ACTIVE:
            begin
                if (~busy)
                begin
                    st_nxt.pwr = PS_LOW; // R1 R2
                end
            end
            default:
            begin
                st_nxt.pwr = PS_LOW;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_r <= ST_RST; // R19
        end
        else if (CLK_EN)
        begin
            st_r <= st_nxt; // R24
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign HRDATA            = st_r.rdata;
    assign HREADYOUT         = 1'b1;
    assign HRESP             = 1'b0;
    assign ROW_OUTPUT        = st_r.row_lvl;
    assign ROW_OUTPUT_OE     = st_r.row_oe;
    assign SCAN_RUNTIME_IRQ  = st_r.irq;
    assign SCAN_WAKE_REQUEST = st_r.wake;
    assign SCAN_WAKE_SIGNAL  = st_r.wake;
    assign SLEEP_INHIBIT     = (st_r.pwr == PS_ACTIVE); // R3
    assign LOW_POWER         = (st_r.pwr == PS_LOW); // R3

endmodule
`default_nettype wire

// ===== tb/keyscan_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module keyscan_monitor
    import keyscan_pkg::*;
(
    input wire logic                CLOCK,
    input wire logic                RST_N,
    input wire logic                HREADYOUT,
    input wire logic                HRESP,
    input wire logic [NUM_ROWS-1:0] ROW_OUTPUT,
    input wire logic [NUM_ROWS-1:0] ROW_OUTPUT_OE,
    input wire logic                BUS_CLK_RUNNING,
    input wire logic                SCAN_RUNTIME_IRQ,
    input wire logic                SCAN_WAKE_REQUEST,
    input wire logic                SCAN_WAKE_SIGNAL,
    input wire logic                SLEEP_INHIBIT,
    input wire logic                LOW_POWER
);
    // ----
    // port checks
    // ----
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [NUM_ROWS-1:0] hi;
    assign hi = ROW_OUTPUT & ROW_OUTPUT_OE;
    sequence s_wake_held; SCAN_WAKE_REQUEST && !BUS_CLK_RUNNING; endsequence
    sequence s_wake_done; SCAN_WAKE_REQUEST && BUS_CLK_RUNNING; endsequence
    property p_okay; HREADYOUT && !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready okay");
    property p_pwr_decode; SLEEP_INHIBIT == !LOW_POWER; endproperty
    a_pwr_decode: assert property (p_pwr_decode) else $error("power decode");
    property p_drive_active; (ROW_OUTPUT_OE != '0) |-> ##[0:1] SLEEP_INHIBIT; endproperty
    a_drive_active: assert property (p_drive_active) else $error("driving in low power");
    property p_open_drain;
        ((ROW_OUTPUT | ROW_OUTPUT_OE) == '1) || (ROW_OUTPUT == '0 && ROW_OUTPUT_OE == '0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("low row not driven");
    property p_pd_max; (hi & $past(hi) & $past(hi, 2)) == '0; endproperty
    a_pd_max: assert property (p_pd_max) else $error("high drive too long");
    property p_pd_start; ((hi & ~$past(hi)) & $past(ROW_OUTPUT)) == '0; endproperty
    a_pd_start: assert property (p_pd_start) else $error("high drive not on rise");
    property p_wake_same; SCAN_WAKE_SIGNAL == SCAN_WAKE_REQUEST; endproperty
    a_wake_same: assert property (p_wake_same) else $error("clock request differs");
    property p_wake_hold; s_wake_held |=> SCAN_WAKE_REQUEST; endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake dropped early");
    property p_wake_clear; s_wake_done |=> !SCAN_WAKE_REQUEST; endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake stuck");
    property p_irq_asleep; !BUS_CLK_RUNNING [*2] |-> !SCAN_RUNTIME_IRQ; endproperty
    a_irq_asleep: assert property (p_irq_asleep) else $error("irq while asleep");
endmodule
bind keyboard_matrix_scan keyscan_monitor u_mon (.CLOCK(CLOCK), .RST_N(RST_N),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ROW_OUTPUT(ROW_OUTPUT),
    .ROW_OUTPUT_OE(ROW_OUTPUT_OE), .BUS_CLK_RUNNING(BUS_CLK_RUNNING),
    .SCAN_RUNTIME_IRQ(SCAN_RUNTIME_IRQ), .SCAN_WAKE_REQUEST(SCAN_WAKE_REQUEST),
    .SCAN_WAKE_SIGNAL(SCAN_WAKE_SIGNAL), .SLEEP_INHIBIT(SLEEP_INHIBIT),
    .LOW_POWER(LOW_POWER));
`default_nettype wire

// ===== tb/key_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module key_matrix
    import keyscan_pkg::*;
(
    input  wire logic [NUM_ROWS-1:0] row_lvl,
    input  wire logic [NUM_ROWS-1:0] row_oe,
    input  wire logic [4:0]          key_row,
    input  wire logic [2:0]          key_col,
    input  wire logic                key_down,
    output logic      [NUM_COLS-1:0] col
);
    // ----
    // switch matrix with pull-ups
    // ----
    logic [NUM_ROWS-1:0] wire_lvl;
    assign wire_lvl = ~row_oe | row_lvl;
    always_comb
    begin
        col = '1;
        if (key_down && !wire_lvl[key_row])
            col[key_col] = 1'b0;
    end
endmodule
`default_nettype wire

// ===== tb/test_keyboard_matrix_scan.sv
`timescale 1ns/1ps
`default_nettype none
module test_keyboard_matrix_scan
    import keyscan_pkg::*;
    ;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = '0;
    logic [1:0]          htrans = '0;
    logic                hwrite = 1'b0;
    logic [31:0]         hwdata = '0;
    logic                bus_run = 1'b1;
    logic [4:0]          key_row = '0;
    logic [2:0]          key_col = '0;
    logic                key_down = 1'b0;
    logic [31:0]         hrdata;
    logic                hready;
    logic [NUM_COLS-1:0] cols;
    logic [NUM_ROWS-1:0] rows;
    logic [NUM_ROWS-1:0] oe;
    logic                irq, wake, wsig, inh, lowp;
    int                  err_count = 0;
    int                  compares = 0;
    always #12.5 clk = ~clk;
    keyboard_matrix_scan dut (.CLOCK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(SIZE_WORD),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(), .COLUMN_INPUT(cols), .BUS_CLK_RUNNING(bus_run), .ROW_OUTPUT(rows),
        .ROW_OUTPUT_OE(oe), .SCAN_RUNTIME_IRQ(irq), .SCAN_WAKE_REQUEST(wake),
        .SCAN_WAKE_SIGNAL(wsig), .SLEEP_INHIBIT(inh), .LOW_POWER(lowp));
    key_matrix u_keys (.row_lvl(rows), .row_oe(oe), .key_row(key_row),
        .key_col(key_col), .key_down(key_down), .col(cols));
    // ----
    // helpers
    // ----
    task automatic stop_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {27'h0, a};
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        q = hrdata;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        check(q, e);
    endtask
    task automatic count_pd(input logic [31:0] ext);
        int n;
        wr(OFS_ROW_SEL, 32'h40);
        wr(OFS_EXT_CTL, ext);
        wr(OFS_ROW_SEL, 32'h00);
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            n += int'(rows[1] & oe[1]);
        end
        check(32'(n), ext[0] ? 32'h2 : 32'h0);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        rd_chk(OFS_ROW_SEL, 32'h40);
        rd_chk(OFS_COL_IEN, 32'h0);
        rd_chk(OFS_EXT_CTL, 32'h0);
        rd_chk(5'h18, 32'h0);
        rd_chk(OFS_COL_IN, 32'hff);
        check(32'(rows), 32'h0);
        check(32'(oe), 32'h0);
        check(32'(lowp), 32'h1);
    endtask
    task automatic t_rows;
        logic [4:0]          sels [5] = '{5'h00, 5'h07, 5'h11, 5'h12, 5'h1f};
        logic                inv, all;
        logic [4:0]          s;
        logic [NUM_ROWS-1:0] lvl;
        for (int m = 0; m < 20; m++)
        begin
            inv = m[0];
            all = m[1];
            s = sels[m / 4];
            wr(OFS_ROW_SEL, {24'h0, inv, 1'b0, all, s});
            tick(3);
            lvl = {NUM_ROWS{~inv}};
            if (!all && s <= ROW_SEL_LAST)
                lvl = lvl ^ (18'h1 << s);
            check(32'(rows), 32'(lvl));
            check(32'(oe), {14'h0, ~lvl});
            if (!all && s <= ROW_SEL_LAST)
                check(32'(inh), 32'h1);
        end
        wr(OFS_ROW_SEL, 32'h40);
        tick(4);
        check(32'(rows), 32'h0);
        check(32'(oe), 32'h0);
        check(32'(lowp), 32'h1);
    endtask
    task automatic t_predrive;
        count_pd(32'h1);
        rd_chk(OFS_EXT_CTL, 32'h1);
        count_pd(32'h0);
    endtask
    task automatic t_irq;
        wr(OFS_COL_IEN, 32'h04);
        key_col <= 3'd2;
        key_down <= 1'b1;
        tick(3);
        rd_chk(OFS_COL_IN, 32'hfb);
        rd_chk(OFS_COL_STAT, 32'h04);
        check(32'(irq), 32'h1);
        wr(OFS_COL_STAT, 32'h0);
        rd_chk(OFS_COL_STAT, 32'h04);
        wr(OFS_COL_STAT, 32'h04);
        tick(2);
        check(32'(irq), 32'h0);
        key_down <= 1'b0;
        tick(2);
        key_col <= 3'd3;
        key_down <= 1'b1;
        tick(3);
        rd_chk(OFS_COL_STAT, 32'h08);
        check(32'(irq), 32'h0);
        key_down <= 1'b0;
        wr(OFS_COL_STAT, 32'h08);
    endtask
    task automatic t_wake;
        bus_run <= 1'b0;
        tick(2);
        key_col <= 3'd2;
        key_down <= 1'b1;
        tick(4);
        check(32'({wake, wsig, irq}), 32'h6);
        bus_run <= 1'b1;
        tick(3);
        check(32'({wake, irq}), 32'h1);
        rd_chk(OFS_COL_STAT, 32'h04);
    endtask
    initial
    begin
        tick(8);
        rst_n <= 1'b1;
        t_reset;
        t_rows;
        t_predrive;
        t_irq;
        t_wake;
        stop_test;
    end
    initial
    begin
        #(25 * 20000);
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
